// [pfc_pkg.sv]
package pfc_pkg;

    // ----------------------------------------------------------------
    // configuration space byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] PFC_OFF_INT_PIN = 8'h3d;
    localparam logic [7:0] PFC_OFF_GRANT_LAT = 8'h3e;
    localparam logic [7:0] PFC_OFF_ENDIAN_CTRL = 8'h40;

    // ----------------------------------------------------------------
    // function numbers
    // ----------------------------------------------------------------
    localparam logic [2:0] PFC_FUNC_CARDBUS = 3'h0;
    localparam logic [2:0] PFC_FUNC_HOST_CTRL = 3'h2;
    localparam logic [2:0] PFC_FUNC_SMART_CARD = 3'h5;

    // ----------------------------------------------------------------
    // interrupt pin encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] PFC_PIN_INTA = 8'h01;
    localparam logic [7:0] PFC_PIN_INTC = 8'h03;
    localparam logic [7:0] PFC_PIN_DEFAULT = 8'h02;

    // ----------------------------------------------------------------
    // grant / latency hint layout and defaults
    // ----------------------------------------------------------------
    localparam logic [15:0] PFC_GRANT_LAT_RESET = 16'h0402;
    localparam logic [7:0] PFC_LAT_RESET = 8'h04;
    localparam logic [7:0] PFC_GNT_RESET = 8'h02;
    localparam int PFC_LAT_MSB = 15;
    localparam int PFC_LAT_LSB = 8;
    localparam int PFC_GNT_MSB = 7;
    localparam int PFC_GNT_LSB = 0;
    localparam int PFC_LOAD_NIB_W = 4;

    // ----------------------------------------------------------------
    // endian control register
    // ----------------------------------------------------------------
    localparam int PFC_SWAP_BIT = 0;
    localparam logic PFC_SWAP_RESET = 1'b0;

    // ----------------------------------------------------------------
    // system control tie bit positions (register lives elsewhere)
    // ----------------------------------------------------------------
    localparam int PFC_SYSCTL_TIE_BIT = 29;
    localparam int PFC_SYSCTL_JOIN_BIT = 28;

    // interrupt line indices
    localparam int PFC_IRQ_A = 0;
    localparam int PFC_IRQ_B = 1;

endpackage : pfc_pkg

// [pfc_quadlet_swap.sv]
`timescale 1ns/1ps
`default_nettype none

// registered quadlet path with optional byte reversal
module pfc_quadlet_swap
    import pfc_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic swap_en_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);

    logic [WIDTH-1:0] data_d; // next quadlet
    logic [WIDTH-1:0] data_q; // registered quadlet

    // ----------------------------------------------------------------
    // byte reversal, one lane per generate step
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] swapped; // lanes in reverse order
    for (genvar i = 0; i < WIDTH / 8; i++) begin : g_lane
        assign swapped[i*8 +: 8] = data_i[WIDTH-8-i*8 +: 8];
    end

    // select straight or reversed
    always_comb begin
        data_d = swap_en_i ? swapped : data_i;
    end

    // register only
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_q <= '0;
        end else begin
            data_q <= data_d;
        end
    end

    assign data_o = data_q;

endmodule : pfc_quadlet_swap

`default_nettype wire

// [pfc_irq_router.sv]
`timescale 1ns/1ps
`default_nettype none

// internal joining of the four interrupt lines
module pfc_irq_router
    import pfc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic irq_b_to_a_tie_i,
    input wire logic irq_join_all_i,
    input wire logic [3:0] irq_req_i,
    output logic [3:0] irq_line_o
);

    logic [3:0] line_d; // next line levels
    logic [3:0] line_q; // registered line levels

    // ----------------------------------------------------------------
    // routing
    // ----------------------------------------------------------------
    always_comb begin
        line_d = irq_req_i;
        if (irq_join_all_i) begin
            // join-all overrides the b-to-a tie
            line_d = '0;
            line_d[PFC_IRQ_A] = |irq_req_i;
        end else if (irq_b_to_a_tie_i) begin
            line_d[PFC_IRQ_A] = irq_req_i[PFC_IRQ_A] | irq_req_i[PFC_IRQ_B];
            line_d[PFC_IRQ_B] = 1'b0;
        end
    end

    // register only
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            line_q <= '0;
        end else begin
            line_q <= line_d;
        end
    end

    assign irq_line_o = line_q;

endmodule : pfc_irq_router

`default_nettype wire

// [pfc_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - pin value: f0 INTA, f2 INTC unless join
// - tie bit routes INTB onto INTA
// - join-all bit merges all four lines
// - smart card pin from select, join gives INTA
// - pin register: 8-bit read-only at 3Dh
// - eeprom present: load hints after global reset
// - no eeprom: hint register reads 0402h
// - latency 15:8, grant 7:0, read-only
// - loader writes only low nibbles
// - hints cleared only by global reset pin
// - swap bit byte-reverses every quadlet
// - swap bit resets 0, read/write
// - endian register reserved bits read zero
module pfc_config_regs
    import pfc_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic global_reset_pin_n_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [2:0] cfg_func_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    input wire logic irq_b_to_a_tie_i,
    input wire logic irq_join_all_i,
    input wire logic [7:0] smart_card_int_sel_i,
    input wire logic eeprom_present_i,
    input wire logic eeprom_load_valid_i,
    input wire logic [3:0] eeprom_latency_nib_i,
    input wire logic [3:0] eeprom_grant_nib_i,
    input wire logic [3:0] func_irq_i,
    output logic [3:0] irq_line_o,
    input wire logic [DATA_W-1:0] dma_wr_quadlet_i,
    output logic [DATA_W-1:0] dma_wr_quadlet_o,
    input wire logic [DATA_W-1:0] dma_rd_quadlet_i,
    output logic [DATA_W-1:0] dma_rd_quadlet_o,
    output logic global_swap_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // true when the access hits the dword holding a byte offset
    function automatic logic hits_dword(input logic [7:0] addr, input logic [7:0] off);
        hits_dword = (addr[7:2] == off[7:2]);
    endfunction : hits_dword

    // ----------------------------------------------------------------
    // global reset pin synchroniser
    // ----------------------------------------------------------------
    // asserts at once, releases after two edges so the hint
    // registers never leave reset in mid-cycle
    logic global_reset_pin_meta_q; // first stage, read only by the second
    logic global_reset_pin_sync_n_q; // synchronised, active low

    always_ff @(posedge ref_clk_i or negedge global_reset_pin_n_i) begin
        if (!global_reset_pin_n_i) begin
            global_reset_pin_meta_q <= 1'b0;
            global_reset_pin_sync_n_q <= 1'b0;
        end else begin
            global_reset_pin_meta_q <= 1'b1;
            global_reset_pin_sync_n_q <= global_reset_pin_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // grant / latency hint register
    // ----------------------------------------------------------------
    // only the global reset pin touches these; reset_i does not
    logic [7:0] latency_hint_d; // next latency field
    logic [7:0] latency_hint_q; // latency field, bits 15:8
    logic [7:0] min_grant_d; // next grant field
    logic [7:0] min_grant_q; // grant field, bits 7:0
    logic load_done_d; // next load-taken flag
    logic load_done_q; // one load per global reset

    // loader update; software has no write path here
    always_comb begin
        latency_hint_d = latency_hint_q;
        min_grant_d = min_grant_q;
        load_done_d = load_done_q;
        // without an eeprom the defaults simply remain
        if (eeprom_present_i && eeprom_load_valid_i && !load_done_q) begin
            // upper nibbles keep their default values
            latency_hint_d[PFC_LOAD_NIB_W-1:0] = eeprom_latency_nib_i;
            min_grant_d[PFC_LOAD_NIB_W-1:0] = eeprom_grant_nib_i;
            load_done_d = 1'b1;
        end
    end

    // register only, cleared by the global pin alone
    always_ff @(posedge ref_clk_i or negedge global_reset_pin_sync_n_q) begin
        if (!global_reset_pin_sync_n_q) begin
            latency_hint_q <= PFC_LAT_RESET;
            min_grant_q <= PFC_GNT_RESET;
            load_done_q <= 1'b0;
        end else begin
            latency_hint_q <= latency_hint_d;
            min_grant_q <= min_grant_d;
            load_done_q <= load_done_d;
        end
    end

    // ----------------------------------------------------------------
    // endian control register
    // ----------------------------------------------------------------
    logic global_swap_d; // next swap bit
    logic global_swap_q; // swap bit

    // only bit 0 of byte lane 0 is writable
    always_comb begin
        global_swap_d = global_swap_q;
        if (cfg_wr_i && cfg_func_i == PFC_FUNC_HOST_CTRL
            && hits_dword(cfg_addr_i, PFC_OFF_ENDIAN_CTRL) && cfg_be_i[0]) begin
            global_swap_d = cfg_wdata_i[PFC_SWAP_BIT];
        end
    end

    // register only
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            global_swap_q <= PFC_SWAP_RESET;
        end else begin
            global_swap_q <= global_swap_d;
        end
    end

    assign global_swap_o = global_swap_q;

    // ----------------------------------------------------------------
    // interrupt pin value per function
    // ----------------------------------------------------------------
    logic [7:0] interrupt_pin_value; // pin byte for the addressed function

    // purely derived from the tie inputs, never stored
    always_comb begin
        interrupt_pin_value = '0;
        case (cfg_func_i)
            PFC_FUNC_CARDBUS: begin
                interrupt_pin_value = PFC_PIN_INTA;
            end
            PFC_FUNC_HOST_CTRL: begin
                interrupt_pin_value = irq_join_all_i ? PFC_PIN_INTA : PFC_PIN_INTC;
            end
            PFC_FUNC_SMART_CARD: begin
                interrupt_pin_value = irq_join_all_i ? PFC_PIN_INTA : smart_card_int_sel_i;
            end
            default: begin
                // functions without a header here read zero
                interrupt_pin_value = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // configuration read path
    // ----------------------------------------------------------------
    logic [31:0] rdata_d; // next read data
    logic [31:0] rdata_q; // registered read data
    logic ack_d; // next acknowledge
    logic ack_q; // one-cycle acknowledge

    // read mux; writes to read-only fields fall through here unused
    always_comb begin
        rdata_d = rdata_q;
        ack_d = cfg_rd_i || cfg_wr_i;
        if (cfg_rd_i) begin
            rdata_d = '0;
            if (hits_dword(cfg_addr_i, PFC_OFF_INT_PIN)) begin
                // byte at 3Ch is the line register, not held here
                rdata_d[15:8] = interrupt_pin_value;
                if (cfg_func_i == PFC_FUNC_HOST_CTRL) begin
                    rdata_d[16 + PFC_LAT_MSB -: 8] = latency_hint_q;
                    rdata_d[16 + PFC_GNT_MSB -: 8] = min_grant_q;
                end
            end else if (hits_dword(cfg_addr_i, PFC_OFF_ENDIAN_CTRL)
                         && cfg_func_i == PFC_FUNC_HOST_CTRL) begin
                // reserved bits stay at zero from the clear above
                rdata_d[PFC_SWAP_BIT] = global_swap_q;
            end else begin
                // unmapped dwords read zero
                rdata_d = '0;
            end
        end
    end

    // register only
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= '0;
            ack_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    assign cfg_rdata_o = rdata_q;
    assign cfg_ack_o = ack_q;

    // ----------------------------------------------------------------
    // data path byte swapping, one cycle latency each way
    // ----------------------------------------------------------------
    // the swap takes effect on the quadlet after the write lands;
    // software should change it only while the link is idle
    pfc_quadlet_swap #(
        .WIDTH(DATA_W)
    ) u_wr_swap (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .swap_en_i(global_swap_q),
        .data_i(dma_wr_quadlet_i),
        .data_o(dma_wr_quadlet_o)
    );

    pfc_quadlet_swap #(
        .WIDTH(DATA_W)
    ) u_rd_swap (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .swap_en_i(global_swap_q),
        .data_i(dma_rd_quadlet_i),
        .data_o(dma_rd_quadlet_o)
    );

    // ----------------------------------------------------------------
    // interrupt joining
    // ----------------------------------------------------------------
    // relies on software having put terminal three in serial irq
    // mode first; this block cannot check that
    pfc_irq_router u_irq_router (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .irq_b_to_a_tie_i(irq_b_to_a_tie_i),
        .irq_join_all_i(irq_join_all_i),
        .irq_req_i(func_irq_i),
        .irq_line_o(irq_line_o)
    );

endmodule : pfc_config_regs

`default_nettype wire

// [pfc_config_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// protocol checker for the config register block
// ------------------------------------------------
module pfc_config_regs_chk
    import pfc_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [2:0] cfg_func_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic irq_b_to_a_tie_i,
    input wire logic irq_join_all_i,
    input wire logic [7:0] smart_card_int_sel_i,
    input wire logic [3:0] func_irq_i,
    input wire logic [3:0] irq_line_o,
    input wire logic [DATA_W-1:0] dma_rd_quadlet_i,
    input wire logic [DATA_W-1:0] dma_rd_quadlet_o,
    input wire logic global_swap_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // dword decode, low address bits ignored
    wire rd_3c = cfg_rd_i && cfg_addr_i[7:2] == PFC_OFF_INT_PIN[7:2];
    wire at_40 = cfg_addr_i[7:2] == PFC_OFF_ENDIAN_CTRL[7:2] && cfg_func_i == PFC_FUNC_HOST_CTRL;
    // only a func 2 write with lane 0 enabled may move the swap bit
    wire wr_sw = cfg_wr_i && cfg_be_i[0] && at_40;
    // byte reversal of one quadlet
    function automatic logic [31:0] swp(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : swp
    pin_f0_a: assert property (rd_3c && cfg_func_i == PFC_FUNC_CARDBUS |=>
        cfg_rdata_o[15:8] == PFC_PIN_INTA) else $error("func 0 pin value wrong");
    pin_f2_a: assert property (rd_3c && cfg_func_i == PFC_FUNC_HOST_CTRL |=>
        cfg_rdata_o[15:8] == ($past(irq_join_all_i) ? PFC_PIN_INTA : PFC_PIN_INTC))
        else $error("func 2 pin value wrong");
    pin_sc_a: assert property (rd_3c && cfg_func_i == PFC_FUNC_SMART_CARD |=>
        cfg_rdata_o[15:8] == ($past(irq_join_all_i) ? PFC_PIN_INTA : $past(smart_card_int_sel_i)))
        else $error("smart card pin value wrong");
    hint_nibble_a: assert property (rd_3c && cfg_func_i == PFC_FUNC_HOST_CTRL |=>
        cfg_rdata_o[31:28] == 4'h0 && cfg_rdata_o[23:20] == 4'h0) else $error("hint upper nibble set");
    endian_read_a: assert property (cfg_rd_i && at_40 |=>
        cfg_rdata_o == {31'h0, $past(global_swap_o)}) else $error("endian readback wrong");
    swap_write_a: assert property (wr_sw |=>
        {31'h0, global_swap_o} == ($past(cfg_wdata_i) & 32'h1)) else $error("swap bit not written");
    swap_hold_a: assert property (!wr_sw |=> $stable(global_swap_o))
        else $error("swap bit moved without write");
    irq_join_a: assert property (irq_join_all_i |=>
        irq_line_o == {3'h0, |$past(func_irq_i)}) else $error("joined lines wrong");
    irq_tie_a: assert property (irq_b_to_a_tie_i && !irq_join_all_i |=>
        irq_line_o == (($past(func_irq_i) & 4'hc) | {3'h0, |($past(func_irq_i) & 4'h3)}))
        else $error("tied lines wrong");
    swap_path_a: assert property (1'b1 |=>
        dma_rd_quadlet_o == ($past(global_swap_o) ? swp($past(dma_rd_quadlet_i)) : $past(dma_rd_quadlet_i)))
        else $error("read quadlet order wrong");
endmodule : pfc_config_regs_chk
bind pfc_config_regs pfc_config_regs_chk #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

// [pfc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// host bridge and config software stand-in
// ------------------------------------------------
module pfc_host_model (
    input wire logic ref_clk_i,
    input wire logic cfg_ack_i,
    input wire logic [31:0] cfg_rdata_i,
    output logic cfg_rd_o,
    output logic cfg_wr_o,
    output logic [2:0] cfg_func_o,
    output logic [7:0] cfg_addr_o,
    output logic [3:0] cfg_be_o,
    output logic [31:0] cfg_wdata_o,
    output logic irq_b_to_a_tie_o,
    output logic irq_join_all_o
);
    logic serial_irq_mode; // terminal three set to serial irq
    initial begin
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        cfg_func_o = 3'h0;
        cfg_addr_o = 8'h00;
        cfg_be_o = 4'h0;
        cfg_wdata_o = 32'h0;
        irq_b_to_a_tie_o = 1'b0;
        irq_join_all_o = 1'b0;
        serial_irq_mode = 1'b0;
    end
    // one config cycle; the request is a single-cycle pulse
    task automatic xfer(input logic wr, input logic [2:0] f, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] q, output logic ack);
        @(posedge ref_clk_i);
        #1;
        cfg_rd_o = !wr;
        cfg_wr_o = wr;
        cfg_func_o = f;
        cfg_addr_o = a;
        cfg_be_o = be;
        cfg_wdata_o = d;
        @(posedge ref_clk_i);
        #1;
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        // released qualifiers flip so stale values are never trusted
        cfg_addr_o = ~a;
        cfg_wdata_o = ~d;
        cfg_be_o = ~be;
        ack = cfg_ack_i;
        q = cfg_rdata_i;
    endtask : xfer
    // serial irq mode goes first, the tie bit a cycle later
    task automatic set_ties(input logic tie, input logic jall);
        @(posedge ref_clk_i);
        #1;
        serial_irq_mode = serial_irq_mode | tie;
        @(posedge ref_clk_i);
        #1;
        irq_b_to_a_tie_o = tie & serial_irq_mode;
        irq_join_all_o = jall;
    endtask : set_ties
endmodule : pfc_host_model
`default_nettype wire

// [pfc_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pfc_pkg::*;
;
    // ------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic global_reset_pin_n = 1'b0; // global reset pin, low active
    logic [7:0] sel = 8'h00;
    logic present = 1'b0;
    logic ld_valid = 1'b0;
    logic [3:0] lat_nib = 4'h0;
    logic [3:0] gnt_nib = 4'h0;
    logic [3:0] irq_in = 4'h0;
    logic [31:0] wr_in = 32'h0;
    logic [31:0] rd_in = 32'h0;
    wire logic rd, wr, ack, tie, jall, swap;
    wire logic [2:0] func;
    wire logic [7:0] addr;
    wire logic [3:0] be, irq_out;
    wire logic [31:0] wdata, rdata, wr_out, rd_out;
    integer seed = 90;
    integer error_cnt = 0;
    integer check_count = 0;
    integer cycles = 0;
    logic [2:0] fn_list [4] = '{PFC_FUNC_CARDBUS, PFC_FUNC_HOST_CTRL, PFC_FUNC_SMART_CARD, 3'h1};
    pfc_config_regs #(.DATA_W(32)) uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .global_reset_pin_n_i(global_reset_pin_n), .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_func_i(func),
        .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
        .irq_b_to_a_tie_i(tie), .irq_join_all_i(jall), .smart_card_int_sel_i(sel),
        .eeprom_present_i(present), .eeprom_load_valid_i(ld_valid), .eeprom_latency_nib_i(lat_nib),
        .eeprom_grant_nib_i(gnt_nib), .func_irq_i(irq_in), .irq_line_o(irq_out),
        .dma_wr_quadlet_i(wr_in), .dma_wr_quadlet_o(wr_out), .dma_rd_quadlet_i(rd_in),
        .dma_rd_quadlet_o(rd_out), .global_swap_o(swap));
    pfc_host_model host (.ref_clk_i(ref_clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdata), .cfg_rd_o(rd),
        .cfg_wr_o(wr), .cfg_func_o(func), .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata),
        .irq_b_to_a_tie_o(tie), .irq_join_all_o(jall));
    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // ------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------
    function automatic logic [7:0] exp_pin(input logic [2:0] f, input logic j, input logic [7:0] s);
        return f == PFC_FUNC_CARDBUS ? PFC_PIN_INTA : f == PFC_FUNC_HOST_CTRL ?
            (j ? PFC_PIN_INTA : PFC_PIN_INTC) : f == PFC_FUNC_SMART_CARD ? (j ? PFC_PIN_INTA : s) : 8'h00;
    endfunction : exp_pin
    function automatic logic [3:0] exp_irq(input logic [3:0] r, input logic t, input logic j);
        return j ? {3'h0, |r} : t ? {r[3:2], 1'b0, r[1] | r[0]} : r;
    endfunction : exp_irq
    function automatic logic [31:0] bsw(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : bsw
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [2:0] f, input logic [7:0] a, output logic [31:0] q);
        logic k;
        host.xfer(1'b0, f, a, 4'h0, 32'h0, q, k);
        chk({31'h0, k}, 32'h1);
    endtask : rdc
    task automatic wrc(input logic [2:0] f, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        logic [31:0] q;
        logic k;
        host.xfer(1'b1, f, a, b, d, q, k);
        chk({31'h0, k}, 32'h1);
    endtask : wrc
    // loader strobe, data lines scrambled once it drops
    task automatic strobe(input logic [3:0] l, input logic [3:0] g);
        @(posedge ref_clk_i);
        #1;
        ld_valid = 1'b1;
        lat_nib = l;
        gnt_nib = g;
        @(posedge ref_clk_i);
        #1;
        ld_valid = 1'b0;
        lat_nib = ~l;
        gnt_nib = ~g;
    endtask : strobe
    task automatic hints(input logic [15:0] e);
        logic [31:0] q;
        rdc(PFC_FUNC_HOST_CTRL, PFC_OFF_GRANT_LAT, q);
        chk({16'h0, q[31:16]}, {16'h0, e});
    endtask : hints
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // hang guard, run needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            summarize();
        end
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        logic [31:0] q;
        logic [3:0] ln, gn;
        logic t, j;
        integer k, m;
        repeat (12) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        global_reset_pin_n = 1'b1;
        rdc(PFC_FUNC_HOST_CTRL, PFC_OFF_INT_PIN, q);
        chk(q, {PFC_GRANT_LAT_RESET, PFC_PIN_INTC, 8'h00});
        rdc(PFC_FUNC_HOST_CTRL, PFC_OFF_ENDIAN_CTRL, q);
        chk(q, {31'h0, PFC_SWAP_RESET});
        $display("test reset done");
        // every tie/join mix, functions 0, 2, 5 and 1, with irq routing
        for (k = 0; k < 16; k++) begin
            t = k[0];
            j = k[1];
            sel = (k == 4) ? 8'hff : 8'($random(seed));
            host.set_ties(t, j);
            for (m = 0; m < 4; m++) begin
                rdc(fn_list[m], PFC_OFF_INT_PIN, q);
                chk({24'h0, q[15:8]}, {24'h0, exp_pin(fn_list[m], j, sel)});
                irq_in = 4'($random(seed));
                @(posedge ref_clk_i);
                #1;
                chk({28'h0, irq_out}, {28'h0, exp_irq(irq_in, t, j)});
            end
        end
        $display("test pins done");
        // writes to read-only places are dropped
        wrc(PFC_FUNC_HOST_CTRL, PFC_OFF_INT_PIN, 4'hf, 32'hffff_ffff);
        wrc(PFC_FUNC_HOST_CTRL, PFC_OFF_ENDIAN_CTRL, 4'he, 32'hffff_ffff);
        wrc(PFC_FUNC_CARDBUS, PFC_OFF_ENDIAN_CTRL, 4'hf, 32'hffff_ffff);
        hints(PFC_GRANT_LAT_RESET);
        rdc(PFC_FUNC_HOST_CTRL, PFC_OFF_ENDIAN_CTRL, q);
        chk(q, 32'h0);
        $display("test read-only done");
        // set then clear the swap bit, quadlets checked each way
        for (k = 0; k < 2; k++) begin
            wrc(PFC_FUNC_HOST_CTRL, PFC_OFF_ENDIAN_CTRL, 4'h1, {31'($random(seed)), ~k[0]});
            rdc(PFC_FUNC_HOST_CTRL, PFC_OFF_ENDIAN_CTRL, q);
            chk(q, {31'h0, ~k[0]});
            repeat (8) begin
                wr_in = $random(seed);
                rd_in = $random(seed);
                @(posedge ref_clk_i);
                #1;
                chk(wr_out, k ? wr_in : bsw(wr_in));
                chk(rd_out, k ? rd_in : bsw(rd_in));
            end
        end
        $display("test swap done");
        // prom load is taken once, survives the plain reset
        present = 1'b1;
        ln = 4'($random(seed));
        gn = 4'($random(seed));
        strobe(ln, gn);
        strobe(~ln, ~gn);
        hints({4'h0, ln, 4'h0, gn});
        reset_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        hints({4'h0, ln, 4'h0, gn});
        global_reset_pin_n = 1'b0;
        hints(PFC_GRANT_LAT_RESET);
        global_reset_pin_n = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        present = 1'b0;
        strobe(ln, gn);
        hints(PFC_GRANT_LAT_RESET);
        present = 1'b1;
        strobe(gn, ln);
        hints({4'h0, gn, 4'h0, ln});
        $display("test prom done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
